/* File: verilog/sc7_pkg.sv */
// Purpose: shared types and constants of the seven stage pipeline core
// Assumes: 16 bit words, 16 working registers, byte addressed memory
// Notes:   instructions arrive predecoded from program memory

package sc7_pkg;

  localparam logic [15:0] SC7_PC_RST  = 16'h0000;
  localparam logic [15:0] SC7_SP_RST  = 16'hFC00;
  localparam logic [15:0] SC7_STEP    = 16'h0002;
  localparam int          SC7_FIFO_DEF = 4;

  typedef enum logic [1:0] {SC7_ADD, SC7_SUB, SC7_MOV, SC7_AND} sc7_op_t;
  typedef enum logic [1:0] {SC7_DUAL_PORT_RAM, SC7_SRAM, SC7_EXT, SC7_NOAREA}
    sc7_area_t;
  typedef enum logic [1:0] {SC7_NOSTK, SC7_PUSH, SC7_POP, SC7_RSVSTK}
    sc7_stk_t;
  typedef enum logic [1:0] {SC7_ALW, SC7_ZS, SC7_ZC, SC7_CS} sc7_cond_t;
  typedef enum logic [1:0] {SC7_MULTI, SC7_IRQ, SC7_PEC, SC7_EMU}
    sc7_inj_t;

  // ind: source from memory at [ptr]; st: result stored at [ptr]
  typedef struct packed {
    sc7_op_t     op;
    logic [3:0]  dst;
    logic [3:0]  src;
    logic [3:0]  ptr;
    logic        ind;
    logic        wr;
    logic        st;
    logic        pinc;
    sc7_stk_t    stk;
    sc7_area_t   area;
    logic [1:0]  cyc;
    logic        br;
    sc7_cond_t   cond;
    logic [15:0] tgt;
  } sc7_insn_t;

  typedef struct packed {
    logic        v;
    logic        inj;
    logic        pt;
    sc7_inj_t    kind;
    sc7_insn_t   i;
    logic [15:0] nxt;
    logic [15:0] adr;
    logic [15:0] pv;
    logic [15:0] a;
    logic [15:0] b;
  } sc7_slot_t;

  typedef struct packed {
    logic z;
    logic n;
    logic c;
  } sc7_flags_t;

  typedef struct packed {
    logic        v;
    sc7_area_t   area;
    logic [15:0] adr;
    logic [15:0] dat;
  } sc7_mreq_t;

endpackage

/* File: verilog/sc7_core.sv */
// Purpose: seven stage instruction pipeline with fetch, FIFO and interlock
// Assumes: program memory answers with pm_ack; data reads return in MEMORY
// Notes:   ce low freezes every flop, including one-cycle pulse outputs

`timescale 1ns/1ps

module sc7_core import sc7_pkg::*; #(
  parameter int FIFO_DEPTH = SC7_FIFO_DEF
) (
  // Clock, reset, enable
  input  wire logic      core_clk,
  input  wire logic      resetn,
  input  wire logic      ce,
  // Program memory unit
  output logic           pm_req_q,
  output logic [15:0]    pm_addr_q,
  input  wire logic      pm_ack,
  input  wire sc7_insn_t pm_insn,
  // Data memory areas
  output sc7_mreq_t      dm_rd_q,
  input  wire logic [15:0] dm_rdata,
  output sc7_mreq_t      dm_wr_q,
  output sc7_mreq_t      sram_wr_q,
  // Injection requests
  input  wire logic      inj_req,
  input  wire sc7_inj_t  inj_kind,
  output logic           inj_ack_q,
  // Status
  output logic           retire_q,
  output logic           stall_q,
  output sc7_flags_t     flags_q,
  output logic [15:0]    stack_pointer_reg_q
);

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [AW:0] FDC = (AW+1)'(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO_DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [15:0]                pc;
    logic [15:0]                pa;
    logic                       req;
    logic                       drop;
    logic                       byp;
    sc7_slot_t                  f;
    sc7_slot_t [FIFO_DEPTH-1:0] fq;
    logic [AW:0]                cnt;
    logic [AW-1:0]              rp;
    logic [AW-1:0]              wp;
    sc7_slot_t                  d;
    sc7_slot_t                  ad;
    sc7_slot_t                  m;
    sc7_slot_t                  e;
    sc7_slot_t                  w;
    logic [1:0]                 dcnt;
    logic [15:0][15:0]          rf;
    logic [15:0]                sp;
    sc7_flags_t                 fl;
    sc7_mreq_t                  rd;
    sc7_mreq_t                  wr;
    sc7_mreq_t                  sb;
    sc7_mreq_t                  so;
    logic                       ack;
    logic                       ret;
    logic                       stl;
  } sc7_st_t;

  sc7_st_t     s_q;
  sc7_st_t     s_d;
  logic        stall;
  logic        mis;
  logic        tk;
  logic [15:0] res;

  // Writer of r in slot x: ALU destination or pointer auto-increment
  function automatic logic alu_w(input sc7_slot_t x, input logic [3:0] r);
    return x.v && ((x.i.wr && x.i.dst == r) || (x.i.pinc && x.i.ptr == r));
  endfunction

  function automatic logic [15:0] rd_fwd(input sc7_st_t s,
                                         input logic [3:0] r,
                                         input logic [15:0] rv);
    rd_fwd = s.rf[r];
    if (s.e.v && s.e.i.pinc && s.e.i.ptr == r) begin
      rd_fwd = s.e.pv + SC7_STEP;
    end
    if (s.e.v && s.e.i.wr && s.e.i.dst == r) begin
      rd_fwd = rv;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sc7_st_t     n;
    sc7_slot_t   ws;
    sc7_flags_t  nf;
    logic [16:0] sum;
    logic [16:0] dif;
    logic        cy;
    logic        uptr;
    logic        busy;
    logic        ack_ok;
    logic        pop;
    logic        push;
    logic        byp_use;
    logic [1:0]  cnow;
    logic [15:0] pv;
    logic [15:0] adr;
    logic [AW-1:0] lw;
    n = s_q;
    ws = '0;
    pop = 1'b0;
    push = 1'b0;
    byp_use = 1'b0;
    nf = '0;
    sum = '0;
    dif = '0;
    cy = 1'b0;
    uptr = 1'b0;
    busy = 1'b0;
    ack_ok = 1'b0;
    cnow = 2'h0;
    pv = '0;
    adr = '0;
    lw = '0;
    // Execute
    sum = {1'b0, s_q.e.a} + {1'b0, s_q.e.b};
    dif = {1'b0, s_q.e.a} - {1'b0, s_q.e.b};
    cy = s_q.fl.c;
    case (s_q.e.i.op)
      SC7_ADD: begin res = sum[15:0]; cy = sum[16]; end
      SC7_SUB: begin res = dif[15:0]; cy = dif[16]; end
      SC7_MOV: res = s_q.e.b;
      SC7_AND: res = s_q.e.a & s_q.e.b;
      default: res = s_q.e.b;
    endcase
    nf = s_q.fl;
    if (s_q.e.v && (s_q.e.i.wr || s_q.e.i.st)) begin
      nf = '{z: res == 16'h0000, n: res[15], c: cy};
    end
    case (s_q.e.i.cond)
      SC7_ALW: tk = 1'b1;
      SC7_ZS:  tk = nf.z;
      SC7_ZC:  tk = !nf.z;
      SC7_CS:  tk = nf.c;
      default: tk = 1'b1;
    endcase
    mis = s_q.e.v && s_q.e.i.br && (tk != s_q.e.pt);
    n.fl = nf;
    // Two execute write ports; destination wins over auto-increment
    if (s_q.e.v && s_q.e.i.pinc) begin
      n.rf[s_q.e.i.ptr] = s_q.e.pv + SC7_STEP;
    end
    if (s_q.e.v && s_q.e.i.wr) begin
      n.rf[s_q.e.i.dst] = res;
    end
    // Write back
    n.w = s_q.e;
    n.w.a = res;
    n.w.b = s_q.e.pv + SC7_STEP;
    n.ret = s_q.e.v && !s_q.e.inj;
    n.wr = '0;
    n.so = '0;
    // SRAM writes wait while a read owns the SRAM port, unless a new SRAM store pushes the buffered one out
    busy = s_q.rd.v && s_q.rd.area == SC7_SRAM;
    if (s_q.sb.v && !busy) begin
      n.so = s_q.sb;
      n.sb.v = 1'b0;
    end
    if (s_q.e.v && (s_q.e.i.st || s_q.e.i.stk == SC7_PUSH)) begin
      if (s_q.e.i.area == SC7_SRAM) begin
        if (s_q.sb.v && busy) begin
          n.so = s_q.sb;
        end
        n.sb = '{v: 1'b1, area: SC7_SRAM, adr: s_q.e.adr, dat: res};
      end else begin
        n.wr = '{v: 1'b1, area: s_q.e.i.area, adr: s_q.e.adr,
                 dat: res};
      end
    end
    // Memory: operands with forwarding from execute
    n.e = s_q.m;
    n.e.a = rd_fwd(s_q, s_q.m.i.dst, res);
    n.e.b = (s_q.m.i.ind || s_q.m.i.stk == SC7_POP) ? dm_rdata
          : rd_fwd(s_q, s_q.m.i.src, res);
    // Address
    uptr = s_q.ad.v && s_q.ad.i.stk == SC7_NOSTK &&
           (s_q.ad.i.ind || s_q.ad.i.st || s_q.ad.i.pinc);
    stall = uptr && (alu_w(s_q.m, s_q.ad.i.ptr) ||
                     alu_w(s_q.e, s_q.ad.i.ptr));
    pv = s_q.ad.pv;
    // Producer now in write back: its result is forwarded here
    if (alu_w(s_q.w, s_q.ad.i.ptr)) begin
      pv = (s_q.w.i.wr && s_q.w.i.dst == s_q.ad.i.ptr) ? s_q.w.a
         : s_q.w.b;
    end
    case (s_q.ad.i.stk)
      SC7_PUSH: adr = s_q.sp - SC7_STEP;
      SC7_POP:  adr = s_q.sp;
      default:  adr = pv;
    endcase
    n.stl = stall;
    n.rd = '0;
    if (stall) begin
      n.m = '0;
    end else begin
      n.m = s_q.ad;
      n.m.adr = adr;
      n.m.pv = pv;
      if (s_q.ad.v && s_q.ad.i.stk == SC7_PUSH) begin
        n.sp = s_q.sp - SC7_STEP;
      end
      if (s_q.ad.v && s_q.ad.i.stk == SC7_POP) begin
        n.sp = s_q.sp + SC7_STEP;
      end
      if (s_q.ad.v && (s_q.ad.i.ind || s_q.ad.i.stk == SC7_POP)) begin
        n.rd = '{v: 1'b1, area: s_q.ad.i.area, adr: adr,
                 dat: 16'h0000};
      end
      n.ad = s_q.d;
    end
    // Prefetch: detect branch and predict (forward conditional: not taken)
    ack_ok = pm_ack && s_q.req && !s_q.drop;
    ws.v = 1'b1;
    ws.i = pm_insn;
    ws.nxt = s_q.pa + SC7_STEP;
    ws.pt = pm_insn.br && (pm_insn.cond == SC7_ALW ||
                           pm_insn.tgt < s_q.pa);
    // Decode: multicycle slots, then events, then FIFO, then bypass
    n.ack = 1'b0;
    if (!s_q.d.v || !stall) begin
      n.d = '0;
      cnow = (s_q.d.v && !s_q.d.inj) ? s_q.d.i.cyc : s_q.dcnt;
      if (cnow != 2'h0) begin
        n.d.v = 1'b1;
        n.d.inj = 1'b1;
        n.d.kind = SC7_MULTI;
        n.dcnt = cnow - 2'h1;
      end else if (inj_req && !s_q.ack) begin
        n.d.v = 1'b1;
        n.d.inj = 1'b1;
        n.d.kind = inj_kind;
        n.ack = 1'b1;
      end else if (s_q.cnt != '0) begin
        n.d = s_q.fq[s_q.rp];
        pop = 1'b1;
      end else if (s_q.byp && ack_ok && !s_q.f.v) begin
        n.d = ws;
        byp_use = 1'b1;
      end
      n.d.pv = s_q.rf[n.d.i.ptr];
    end
    // Fetch: next pointer, fold branch into the previous entry
    lw = s_q.wp - 1'b1;
    if (s_q.f.v) begin
      n.f = '0;
      if (s_q.f.i.br && s_q.cnt > {{AW{1'b0}}, pop} &&
          !s_q.fq[lw].i.br) begin
        n.fq[lw].i.br = 1'b1;
        n.fq[lw].i.cond = s_q.f.i.cond;
        n.fq[lw].i.tgt = s_q.f.i.tgt;
        n.fq[lw].pt = s_q.f.pt;
        n.fq[lw].nxt = s_q.f.nxt;
      end else begin
        n.fq[s_q.wp] = s_q.f;
        n.wp = s_q.wp + 1'b1;
        push = 1'b1;
      end
    end
    if (pop) begin
      n.rp = s_q.rp + 1'b1;
    end
    n.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (pm_ack && s_q.req) begin
      n.req = 1'b0;
      n.drop = 1'b0;
    end
    if (ack_ok) begin
      n.byp = 1'b0;
      n.pc = ws.pt ? ws.i.tgt : ws.nxt;
      if (!byp_use) begin
        n.f = ws;
      end
    end
    // One request in flight, reissued at the answer edge so the FIFO
    // can fill; room is kept for the word still on its way
    if ((!s_q.req || (pm_ack && s_q.req)) &&
        n.cnt + {{AW{1'b0}}, n.f.v} < FDC) begin
      n.req = 1'b1;
      n.pa = n.pc;
    end
    // Misprediction: flush younger work, restart fetch on the bypass
    if (mis) begin
      n.f = '0;
      n.d = '0;
      n.ad = '0;
      n.m = '0;
      n.e = '0;
      n.cnt = '0;
      n.rp = '0;
      n.wp = '0;
      n.dcnt = 2'h0;
      n.ack = 1'b0;
      n.rd = '0;
      n.stl = 1'b0;
      n.sp = s_q.sp;
      n.byp = 1'b1;
      n.pc = tk ? s_q.e.i.tgt : s_q.e.nxt;
      n.drop = n.req;
    end
    s_d = n;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.pc <= SC7_PC_RST;
      s_q.sp <= SC7_SP_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign pm_req_q            = s_q.req;
  assign pm_addr_q           = s_q.pa;
  assign dm_rd_q             = s_q.rd;
  assign dm_wr_q             = s_q.wr;
  assign sram_wr_q           = s_q.so;
  assign inj_ack_q           = s_q.ack;
  assign retire_q            = s_q.ret;
  assign stall_q             = s_q.stl;
  assign flags_q             = s_q.fl;
  assign stack_pointer_reg_q = s_q.sp;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn || !ce);

  property p_stall_dist;
    s_q.ad.v && s_q.ad.i.ind && s_q.ad.i.stk == SC7_NOSTK &&
    alu_w(s_q.m, s_q.ad.i.ptr) |-> stall;
  endproperty
  a_stall_dist: assert property (p_stall_dist)
    else $error("pointer hazard not stalled");

  property p_bubble;
    stall && !mis |=> !s_q.m.v && s_q.ad == $past(s_q.ad) && s_q.stl;
  endproperty
  a_bubble: assert property (p_bubble)
    else $error("stall did not hold address stage");

  property p_stall_len;
    stall ##1 stall |=> !stall;
  endproperty
  a_stall_len: assert property (p_stall_len)
    else $error("pointer stall lasted over two cycles");

  property p_order;
    s_q.m.v && !mis |=> s_q.e.v ##1 s_q.w.v;
  endproperty
  a_order: assert property (p_order)
    else $error("instruction skipped a stage");

  property p_push;
    s_q.ad.v && s_q.ad.i.stk == SC7_PUSH && !stall && !mis
      |=> s_q.sp == $past(s_q.sp) - SC7_STEP;
  endproperty
  a_push: assert property (p_push)
    else $error("stack pointer not decremented");

  property p_read;
    s_q.ad.v && s_q.ad.i.ind && !stall && !mis
      |=> dm_rd_q.v && s_q.m.v && dm_rd_q.adr == s_q.m.adr;
  endproperty
  a_read: assert property (p_read)
    else $error("operand read not issued");

  property p_sram;
    s_q.e.v && s_q.e.i.st && s_q.e.i.area == SC7_SRAM
      |=> s_q.sb.v && !dm_wr_q.v;
  endproperty
  a_sram: assert property (p_sram)
    else $error("SRAM store bypassed the buffer");

  property p_multi;
    s_q.d.v && !s_q.d.inj && s_q.d.i.cyc != 2'h0 && !stall && !mis
      |=> s_q.d.v && s_q.d.inj;
  endproperty
  a_multi: assert property (p_multi)
    else $error("no injected slot after multicycle");

  property p_event;
    inj_ack_q |-> s_q.d.v && s_q.d.inj && s_q.d.kind != SC7_MULTI;
  endproperty
  a_event: assert property (p_event)
    else $error("event acknowledged without injection");

  property p_mis;
    mis |=> s_q.byp && !s_q.d.v && !s_q.m.v && s_q.cnt == '0;
  endproperty
  a_mis: assert property (p_mis)
    else $error("mispredict did not flush");

  c_stall: cover property (stall ##1 stall ##1 !stall);
  c_mis:   cover property (mis ##[1:20] retire_q);
  c_fold:  cover property (s_q.f.v && s_q.f.i.br && s_q.wp == s_d.wp);
  c_sram:  cover property (s_q.sb.v && !sram_wr_q.v ##1 sram_wr_q.v);

endmodule

/* File: verif/sc7_mem.sv */
// Purpose: program memory and data memory stand-in for the pipeline core
// Assumes: program and data word loaded by the bench before reset release
// Notes:   prompt answers, random latency once slow is set; idle outputs
//          show a moving pattern

`timescale 1ns/1ps

module sc7_mem import sc7_pkg::*; (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Program memory side
  input  wire logic        pm_req_q,
  input  wire logic [15:0] pm_addr_q,
  output sc7_insn_t        pm_insn,
  output logic             pm_ack,
  // Data memory side
  input  wire sc7_mreq_t   dm_rd_q,
  output logic [15:0]      dm_rdata
);
  sc7_insn_t   prog [256];
  logic [15:0] dval;
  logic [15:0] idle_q;
  integer      seed;
  logic        slow;

  // Unselected read data never repeats the last word
  assign dm_rdata = !dm_rd_q.v ? idle_q :
                    (dm_rd_q.adr == 16'h0000) ? dval : ~dm_rd_q.adr;

  initial begin
    seed    = 32'h0666;
    slow    = 1'b0;
    pm_ack  = 1'b0;
    pm_insn = '0;
    idle_q  = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // One answer per request, after zero or more wait cycles
  always @(posedge core_clk) begin
    idle_q  <= idle_q + 16'h1235;
    pm_ack  <= 1'b0;
    pm_insn <= ~pm_insn;
    if (resetn && pm_req_q && !pm_ack &&
        (!slow || {$random(seed)} % 3 == 0)) begin
      pm_ack  <= 1'b1;
      pm_insn <= prog[pm_addr_q[8:1]];
    end
  end
endmodule

/* File: verif/tb.sv */
// Purpose: self-checking bench for the seven stage pipeline core
// Assumes: indirect read address equals the pointer register value
// Notes:   ce is held high; injection runs after the program section

`timescale 1ns/1ps

module tb import sc7_pkg::*;;
  logic        core_clk;
  logic        resetn;
  logic        ce;
  logic        pm_req_q;
  logic        pm_ack;
  logic [15:0] pm_addr_q;
  sc7_insn_t   pm_insn;
  sc7_mreq_t   dm_rd_q;
  sc7_mreq_t   dm_wr_q;
  sc7_mreq_t   sram_wr_q;
  logic [15:0] dm_rdata;
  logic        inj_req;
  sc7_inj_t    inj_kind;
  logic        inj_ack_q;
  logic        retire_q;
  logic        stall_q;
  sc7_flags_t  flags_q;
  logic [15:0] sp_q;
  logic [15:0] dval;
  logic [15:0] rd_log [$];
  logic [15:0] wr_log [$];
  logic [15:0] sw_log [$];
  integer      seed;
  int          num_errors;
  int          comparisons;
  int          stalls;
  int          cycles;

  sc7_core i_dut (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .pm_req_q(pm_req_q), .pm_addr_q(pm_addr_q), .pm_ack(pm_ack),
    .pm_insn(pm_insn), .dm_rd_q(dm_rd_q), .dm_rdata(dm_rdata),
    .dm_wr_q(dm_wr_q), .sram_wr_q(sram_wr_q), .inj_req(inj_req),
    .inj_kind(inj_kind), .inj_ack_q(inj_ack_q), .retire_q(retire_q),
    .stall_q(stall_q), .flags_q(flags_q), .stack_pointer_reg_q(sp_q));

  sc7_mem i_mem (.core_clk(core_clk), .resetn(resetn),
    .pm_req_q(pm_req_q), .pm_addr_q(pm_addr_q), .pm_insn(pm_insn),
    .pm_ack(pm_ack), .dm_rd_q(dm_rd_q), .dm_rdata(dm_rdata));

  ////////////////////////////////////////////////////////////////////////
  function automatic sc7_insn_t mk(sc7_op_t op, logic [3:0] d, logic [3:0] s,
      logic ind, logic wr, sc7_stk_t stk, logic br, logic [15:0] tgt);
    mk      = '0;
    mk.op   = op;
    mk.dst  = d;
    mk.src  = s;
    mk.ptr  = s;
    mk.ind  = ind;
    mk.wr   = wr;
    mk.stk  = stk;
    mk.br   = br;
    mk.cond = SC7_ALW;
    mk.tgt  = tgt;
    mk.area = (ind || stk != SC7_NOSTK) ? SC7_DUAL_PORT_RAM : SC7_NOAREA;
  endfunction

  function automatic logic [15:0] exp_adr(int n);
    exp_adr = 16'(n) * dval;
  endfunction

  task automatic chk_val(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(logic got, logic exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic inject(sc7_inj_t k);
    logic got;
    got = 1'b0;
    @(posedge core_clk);
    inj_req  <= 1'b1;
    inj_kind <= k;
    for (int w = 0; w < 60 && !got; w++) begin
      @(posedge core_clk);
      #1;
      got = (inj_ack_q === 1'b1);
    end
    chk_bit(got, 1'b1);
    @(posedge core_clk);
    inj_req <= 1'b0;
    #1;
    chk_bit(inj_ack_q, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  always #20 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      final_report();
    end
  end

  // Settled values are observed half a cycle after each edge
  always @(negedge core_clk) begin
    if (resetn === 1'b1 && stall_q === 1'b1)
      stalls++;
    if (resetn === 1'b1 && dm_rd_q.v === 1'b1)
      rd_log.push_back(dm_rd_q.adr);
    if (resetn === 1'b1 && dm_wr_q.v === 1'b1)
      wr_log.push_back(dm_wr_q.adr);
    if (resetn === 1'b1 && sram_wr_q.v === 1'b1)
      sw_log.push_back(sram_wr_q.adr);
  end

  initial begin
    seed     = 32'h0666;
    core_clk = 1'b0;
    resetn   = 1'b0;
    ce       = 1'b1;
    inj_req  = 1'b0;
    inj_kind = SC7_IRQ;
    dval     = ({$random(seed)} & 16'h3FFE) | 16'h0010;
    i_mem.dval = dval;
    // Multicycle fillers let the FIFO fill so hazards meet back to back
    for (int i = 0; i < 256; i++) begin
      i_mem.prog[i] = mk(SC7_MOV, 4'hF, 4'hF, 0, 1, SC7_NOSTK, 0, 16'h0000);
      i_mem.prog[i].cyc = 2'h3;
    end
    i_mem.prog[10] = mk(SC7_MOV, 4'hF, 4'hF, 0, 1, SC7_NOSTK, 0, 16'h0000);
    i_mem.prog[16] = mk(SC7_MOV, 4'hF, 4'hF, 0, 1, SC7_NOSTK, 0, 16'h0000);
    i_mem.prog[17] = mk(SC7_MOV, 4'hF, 4'hF, 0, 1, SC7_NOSTK, 0, 16'h0000);
    i_mem.prog[26] = mk(SC7_MOV, 4'hF, 4'h2, 0, 0, SC7_NOSTK, 0, 16'h0000);
    i_mem.prog[26].st   = 1'b1;
    i_mem.prog[26].area = SC7_SRAM;
    i_mem.prog[0]  = mk(SC7_MOV, 4'h1, 4'h2, 1, 1, SC7_NOSTK, 0, 16'h0000);
    i_mem.prog[4]  = mk(SC7_ADD, 4'h0, 4'h1, 0, 1, SC7_NOSTK, 0, 16'h0000);
    i_mem.prog[5]  = mk(SC7_MOV, 4'h3, 4'h0, 1, 1, SC7_NOSTK, 0, 16'h0000);
    i_mem.prog[9]  = mk(SC7_ADD, 4'h0, 4'h1, 0, 1, SC7_NOSTK, 0, 16'h0000);
    i_mem.prog[11] = mk(SC7_MOV, 4'h4, 4'h0, 1, 1, SC7_NOSTK, 0, 16'h0000);
    i_mem.prog[15] = mk(SC7_ADD, 4'h0, 4'h1, 0, 1, SC7_NOSTK, 0, 16'h0000);
    // Two spacers keep this use free of the interlock
    i_mem.prog[18] = mk(SC7_MOV, 4'h5, 4'h0, 1, 1, SC7_NOSTK, 0, 16'h0000);
    i_mem.prog[22] = mk(SC7_MOV, 4'hF, 4'hF, 0, 0, SC7_NOSTK, 1, 16'h0030);
    i_mem.prog[23] = mk(SC7_MOV, 4'hF, 4'hF, 0, 0, SC7_PUSH, 0, 16'h0000);
    i_mem.prog[24] = mk(SC7_MOV, 4'hF, 4'hF, 0, 0, SC7_PUSH, 0, 16'h0000);
    repeat (16) @(posedge core_clk);
    chk_bit(pm_req_q, 1'b0);
    resetn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk_bit(pm_req_q, 1'b1);
    chk_val(pm_addr_q, SC7_PC_RST);
    chk_val(sp_q, SC7_SP_RST);
    chk_bit(retire_q, 1'b0);
    repeat (250) @(posedge core_clk);
    chk_val(16'(rd_log.size()), 16'h0004);
    for (int n = 0; n < 4; n++)
      chk_val(rd_log[n], exp_adr(n));
    chk_val(16'(stalls), 16'h0003);
    chk_val(sp_q, SC7_SP_RST - SC7_STEP);
    chk_val(16'(wr_log.size()), 16'h0001);
    chk_val(wr_log[0], SC7_SP_RST - SC7_STEP);
    chk_val(16'(sw_log.size()), 16'h0001);
    chk_val(sw_log[0], 16'h0000);
    chk_val(16'(flags_q), 16'h0004);
    i_mem.slow = 1'b1;
    for (int i = 0; i < 5; i++)
      inject(i < 3 ? sc7_inj_t'(i + 1)
                   : sc7_inj_t'({$random(seed)} % 3 + 1));
    final_report();
  end
endmodule
